// ### hdl/iec_cfg.svh
`ifndef IEC_CFG_SVH
`define IEC_CFG_SVH

`define IEC_ADDR_W          8
`define IEC_OFS_CTRL        8'h00
`define IEC_OFS_CMP0        8'h04
`define IEC_OFS_CMP1        8'h08
`define IEC_OFS_COUNT       8'h0C
`define IEC_OFS_STATUS      8'h10

`define IEC_CTRL_W          7
`define IEC_CTRL_RUN_POS    0
`define IEC_CTRL_MODE_LSB   1
`define IEC_CTRL_MODE_MSB   3
`define IEC_CTRL_EVSEL_POS  4
`define IEC_CTRL_FALL_POS   5
`define IEC_CTRL_MASK1_POS  6
`define IEC_STAT_TOG0_POS   0
`define IEC_STAT_TOG1_POS   1
`define IEC_STAT_RUN_POS    2

`define IEC_CTRL_RST        7'h00
`define IEC_CMP_RST         16'h0000
`define IEC_CNT_IDLE        16'hFFFF
`define IEC_CNT_ZERO        16'h0000
`define IEC_PRESC_DIV       1

`endif

// ### hdl/iec_pkg.sv
`include "iec_cfg.svh"
package iec_pkg;

   typedef enum logic [2:0] {
      IEC_MODE_IVL = 3'h0,
      IEC_MODE_EVT = 3'h1
   } iec_mode_t;

   typedef enum logic [2:0] {
      IEC_ST_IDLE = 3'b001,
      IEC_ST_WAIT = 3'b010,
      IEC_ST_RUN  = 3'b100
   } iec_state_t;

   typedef struct packed {
      logic      mask1;
      logic      edge_fall;
      logic      evt_sel;
      iec_mode_t mode;
      logic      run;
   } iec_ctrl_t;

endpackage

// ### hdl/iec_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "iec_cfg.svh"
module iec_prescale #(
   parameter int unsigned DIV = `IEC_PRESC_DIV
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   output var  logic tick_o
);
   logic [15:0] cnt_q;

   if (DIV < 1 || DIV > 65536) begin : g_chk
      $error("iec_prescale: DIV out of range");
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_q  <= 16'h0000;
         tick_o <= 1'b0;
      end else if (cnt_q == 16'(DIV - 1)) begin
         cnt_q  <= 16'h0000;
         tick_o <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule // iec_prescale
`default_nettype wire

// ### hdl/iec_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module iec_edge_detect (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   input  wire logic fall_sel_i,
   output var  logic edge_o
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // Two-stage synchroniser, then one history stage for the edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Only one polarity ever counts
   always_comb begin
      edge_o = fall_sel_i ? (prev_q & ~sync2_q) : (~prev_q & sync2_q);
   end
endmodule // iec_edge_detect
`default_nettype wire

// ### hdl/iec_counter_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iec_cfg.svh"
module iec_counter_top #(
   parameter int unsigned PRESC_DIV = `IEC_PRESC_DIV
) (
   input  wire logic                   CLK_I,
   input  wire logic                   RESET_I,
   input  wire logic                   PSEL_I,
   input  wire logic                   PENABLE_I,
   input  wire logic                   PWRITE_I,
   input  wire logic [`IEC_ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]            PWDATA_I,
   output var  logic [31:0]            PRDATA_O,
   output var  logic                   PREADY_O,
   output var  logic                   PSLVERR_O,
   input  wire logic                   EVENT_INPUT_PIN_I,
   output var  logic                   TOGGLE_OUTPUT_ZERO_O,
   output var  logic                   TOGGLE_OUTPUT_ONE_O,
   output var  logic                   MATCH_IRQ_ZERO_O,
   output var  logic                   MATCH_IRQ_ONE_O,
   output var  logic                   OVERFLOW_IRQ_O
);

   iec_pkg::iec_ctrl_t  ctrl_q;
   iec_pkg::iec_state_t state_q;
   logic [15:0]         compare_reg_zero_q;
   logic [15:0]         compare_reg_one_q;
   logic [15:0]         compare_shadow_zero_q;
   logic [15:0]         compare_shadow_one_q;
   logic [15:0]         cnt_q;
   logic [15:0]         cnt_inc;
   logic                presc_tick;
   logic                event_edge;
   logic                tick;
   logic                ivl_mode;
   logic                evt_mode;
   logic                active;
   logic                running;
   logic                start_step;
   logic                hit0;
   logic                hit1;
   logic                apb_setup;
   logic                apb_wr;
   logic                wr_ctrl;
   logic                wr_cmp0;
   logic                wr_cmp1;
   logic [31:0]         rd_data;
   logic                rd_err;

   //---------------- Count sources
   iec_prescale #(
      .DIV (PRESC_DIV)
   ) u_presc (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .tick_o  (presc_tick)
   );

   iec_edge_detect u_edge (
      .clk_i      (CLK_I),
      .reset_i    (RESET_I),
      .pin_i      (EVENT_INPUT_PIN_I),
      .fall_sel_i (ctrl_q.edge_fall),
      .edge_o     (event_edge)
   );

   always_comb begin
      ivl_mode = (ctrl_q.mode == iec_pkg::IEC_MODE_IVL);
      evt_mode = (ctrl_q.mode == iec_pkg::IEC_MODE_EVT);
      active   = ctrl_q.run & (ivl_mode | evt_mode);
      // Event edges drive event mode, or interval mode when selected
      tick     = (evt_mode | ctrl_q.evt_sel) ? event_edge : presc_tick;
      running  = active & (state_q == iec_pkg::IEC_ST_RUN);
      start_step = active & (state_q == iec_pkg::IEC_ST_WAIT) & tick;
      cnt_inc  = cnt_q + 16'h0001;
   end

   // Interval mode matches on the clearing count; event mode on the count that reaches the buffer
   always_comb begin
      hit0 = 1'b0;
      hit1 = 1'b0;
      if (running && tick) begin
         if (evt_mode) begin
            hit0 = (cnt_inc == compare_shadow_zero_q);
            hit1 = (cnt_inc == compare_shadow_one_q);
         end else begin
            hit0 = (cnt_q == compare_shadow_zero_q);
            hit1 = (cnt_q == compare_shadow_one_q);
         end
      end
   end

   //---------------- APB slave
   always_comb begin
      apb_setup = PSEL_I & ~PENABLE_I;
      apb_wr    = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
      wr_ctrl   = apb_wr & (PADDR_I == `IEC_OFS_CTRL);
      wr_cmp0   = apb_wr & (PADDR_I == `IEC_OFS_CMP0);
      wr_cmp1   = apb_wr & (PADDR_I == `IEC_OFS_CMP1);
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      unique case (PADDR_I)
         `IEC_OFS_CTRL:   rd_data[`IEC_CTRL_W-1:0] = ctrl_q;
         `IEC_OFS_CMP0:   rd_data[15:0] = compare_reg_zero_q;
         `IEC_OFS_CMP1:   rd_data[15:0] = compare_reg_one_q;
         // Stopped counter reads as zero although it holds FFFFH
         `IEC_OFS_COUNT:  rd_data[15:0] = running ? cnt_q : `IEC_CNT_ZERO;
         `IEC_OFS_STATUS: begin
            rd_data[`IEC_STAT_TOG0_POS] = TOGGLE_OUTPUT_ZERO_O;
            rd_data[`IEC_STAT_TOG1_POS] = TOGGLE_OUTPUT_ONE_O;
            rd_data[`IEC_STAT_RUN_POS]  = running;
         end
         default:         rd_err = 1'b1;
      endcase
   end

   // One-cycle ready in the first access cycle
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         PREADY_O  <= 1'b0;
         PRDATA_O  <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= apb_setup;
         if (apb_setup) begin
            PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_data;
            PSLVERR_O <= rd_err;
         end else begin
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         ctrl_q <= iec_pkg::iec_ctrl_t'(`IEC_CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_q <= iec_pkg::iec_ctrl_t'(PWDATA_I[`IEC_CTRL_W-1:0]);
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         compare_reg_zero_q <= `IEC_CMP_RST;
         compare_reg_one_q  <= `IEC_CMP_RST;
      end else begin
         if (wr_cmp0) begin
            compare_reg_zero_q <= PWDATA_I[15:0];
         end
         if (wr_cmp1) begin
            compare_reg_one_q <= PWDATA_I[15:0];
         end
      end
   end

   //---------------- Compare buffers: loaded at start, rewritten at once while running
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         compare_shadow_zero_q <= `IEC_CMP_RST;
         compare_shadow_one_q  <= `IEC_CMP_RST;
      end else if (active && state_q == iec_pkg::IEC_ST_IDLE) begin
         compare_shadow_zero_q <= compare_reg_zero_q;
         compare_shadow_one_q  <= compare_reg_one_q;
      end else if (active) begin
         if (wr_cmp0) begin
            compare_shadow_zero_q <= PWDATA_I[15:0];
         end
         if (wr_cmp1) begin
            compare_shadow_one_q <= PWDATA_I[15:0];
         end
      end
   end

   //---------------- Sequencer
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_q <= iec_pkg::IEC_ST_IDLE;
      end else if (!active) begin
         state_q <= iec_pkg::IEC_ST_IDLE;
      end else begin
         unique case (state_q)
            iec_pkg::IEC_ST_IDLE: begin
               state_q <= evt_mode ? iec_pkg::IEC_ST_RUN : iec_pkg::IEC_ST_WAIT;
            end
            iec_pkg::IEC_ST_WAIT: begin
               if (tick) begin
                  state_q <= iec_pkg::IEC_ST_RUN;
               end
            end
            iec_pkg::IEC_ST_RUN: begin
               state_q <= iec_pkg::IEC_ST_RUN;
            end
            default: begin
               state_q <= iec_pkg::IEC_ST_IDLE;
            end
         endcase
      end
   end

   //---------------- Counter
   always_ff @(posedge CLK_I) begin
      if (RESET_I || !active) begin
         cnt_q <= `IEC_CNT_IDLE;
      end else if (state_q == iec_pkg::IEC_ST_IDLE) begin
         cnt_q <= evt_mode ? `IEC_CNT_ZERO : `IEC_CNT_IDLE;
      end else if (start_step) begin
         cnt_q <= `IEC_CNT_ZERO;
      end else if (running && tick) begin
         if (cnt_q == compare_shadow_zero_q) begin
            cnt_q <= `IEC_CNT_ZERO;
         end else begin
            // Plain wrap past FFFFH when the buffer lies behind the count
            cnt_q <= cnt_inc;
         end
      end
   end

   //---------------- Outputs
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         TOGGLE_OUTPUT_ZERO_O <= 1'b0;
         TOGGLE_OUTPUT_ONE_O  <= 1'b0;
      end else if (ivl_mode) begin
         if (start_step || hit0) begin
            TOGGLE_OUTPUT_ZERO_O <= ~TOGGLE_OUTPUT_ZERO_O;
         end
         if (hit1) begin
            TOGGLE_OUTPUT_ONE_O <= ~TOGGLE_OUTPUT_ONE_O;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         MATCH_IRQ_ZERO_O <= 1'b0;
         MATCH_IRQ_ONE_O  <= 1'b0;
         OVERFLOW_IRQ_O   <= 1'b0;
      end else begin
         MATCH_IRQ_ZERO_O <= hit0;
         MATCH_IRQ_ONE_O  <= hit1 & ~ctrl_q.mask1;
         // Neither mode ever signals overflow, not even on the FFFFH wrap
         OVERFLOW_IRQ_O   <= 1'b0;
      end
   end

   //---------------- Checks
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   chk_start_step: assert property (
      start_step && ivl_mode && !wr_ctrl |=> cnt_q == 16'h0000 && TOGGLE_OUTPUT_ZERO_O != $past(TOGGLE_OUTPUT_ZERO_O))
      else $error("start step did not clear counter or toggle output zero");

   chk_ivl_period: assert property (
      running && ivl_mode && tick && cnt_q == compare_shadow_zero_q && !wr_ctrl
      |=> cnt_q == 16'h0000 && MATCH_IRQ_ZERO_O)
      else $error("interval match did not clear and interrupt");

   chk_no_overflow: assert property (
      !OVERFLOW_IRQ_O)
      else $error("overflow interrupt raised");

   chk_cmp_immediate: assert property (
      wr_cmp0 && active && state_q != iec_pkg::IEC_ST_IDLE
      |=> compare_shadow_zero_q == $past(PWDATA_I[15:0]))
      else $error("compare zero write not buffered at once");

   chk_wrap_silent: assert property (
      running && tick && cnt_q == 16'hFFFF && compare_shadow_zero_q != 16'hFFFF && !wr_ctrl
      |=> cnt_q == 16'h0000 && !MATCH_IRQ_ZERO_O)
      else $error("wrap past FFFFH raised a match");

   chk_equal_match: assert property (
      hit0 && compare_shadow_one_q == compare_shadow_zero_q && !ctrl_q.mask1
      |=> MATCH_IRQ_ONE_O && MATCH_IRQ_ZERO_O)
      else $error("equal compares did not match together");

   chk_one_holds: assert property (
      !hit1 |=> $stable(TOGGLE_OUTPUT_ONE_O))
      else $error("output one moved without a match");

   chk_evt_first_edge: assert property (
      start_step && ctrl_q.evt_sel && !wr_ctrl |=> cnt_q == 16'h0000 && state_q == iec_pkg::IEC_ST_RUN)
      else $error("first event edge did not start the counter");

   chk_evt_no_output: assert property (
      evt_mode |=> $stable(TOGGLE_OUTPUT_ZERO_O) && $stable(TOGGLE_OUTPUT_ONE_O))
      else $error("toggle output moved in event count mode");

   chk_evt_start_load: assert property (
      active && evt_mode && state_q == iec_pkg::IEC_ST_IDLE && !wr_ctrl
      |=> cnt_q == 16'h0000 && compare_shadow_zero_q == $past(compare_reg_zero_q))
      else $error("event mode start did not load buffer and zero the counter");

   chk_evt_first_irq: assert property (
      running && evt_mode && tick && cnt_inc == compare_shadow_zero_q |=> MATCH_IRQ_ZERO_O)
      else $error("event match zero missing when count reached buffer");

   chk_evt_clear: assert property (
      running && evt_mode && tick && cnt_q == compare_shadow_zero_q && !wr_ctrl |=> cnt_q == 16'h0000)
      else $error("event mode did not clear on match");

   chk_single_count: assert property (
      running && !tick && !wr_ctrl |=> $stable(cnt_q))
      else $error("counter moved without a count edge");

   chk_ivl_ffff_wrap: assert property (
      running && ivl_mode && tick && cnt_q == 16'hFFFF && compare_shadow_zero_q == 16'hFFFF && !wr_ctrl
      |=> cnt_q == 16'h0000 && MATCH_IRQ_ZERO_O && !OVERFLOW_IRQ_O)
      else $error("interval compare FFFFH did not match cleanly");

   chk_evt_ffff_match: assert property (
      running && evt_mode && tick && cnt_q == 16'hFFFE && compare_shadow_zero_q == 16'hFFFF && !wr_ctrl
      |=> cnt_q == 16'hFFFF && MATCH_IRQ_ZERO_O && !OVERFLOW_IRQ_O)
      else $error("event compare FFFFH did not match");

   chk_zero_toggles: assert property (
      hit0 && ivl_mode |=> TOGGLE_OUTPUT_ZERO_O != $past(TOGGLE_OUTPUT_ZERO_O))
      else $error("interval match did not toggle output zero");

   chk_one_toggles: assert property (
      hit1 && ivl_mode |=> TOGGLE_OUTPUT_ONE_O != $past(TOGGLE_OUTPUT_ONE_O))
      else $error("match one did not toggle output one");

   chk_evt_match_one: assert property (
      running && evt_mode && tick && cnt_inc == compare_shadow_one_q && !ctrl_q.mask1
      |=> MATCH_IRQ_ONE_O)
      else $error("event mode match one missing");

   chk_mask_gate: assert property (
      hit1 && ctrl_q.mask1 |=> !MATCH_IRQ_ONE_O)
      else $error("masked match one still raised");

   cov_ivl_match: cover property (running && ivl_mode && hit0 && hit1);
   cov_evt_match: cover property (running && evt_mode && hit0);
   cov_wrap:      cover property (running && tick && cnt_q == 16'hFFFF && compare_shadow_zero_q != 16'hFFFF);
   cov_evt_ivl:   cover property (start_step && ctrl_q.evt_sel);
   cov_masked:    cover property (hit1 && ctrl_q.mask1);

endmodule // iec_counter_top
`default_nettype wire

// ### verif/iec_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
module iec_evt_src #(
   parameter int HALF = 6
) (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [15:0] n_i,
   output var  logic        pin_o,
   output var  logic [15:0] edges_o,
   output var  logic        busy_o
);
   logic [15:0] left_q = 16'h0000;
   logic [7:0]  tmr_q  = 8'h00;
   initial pin_o = 1'b0;
   initial edges_o = 16'h0000;
   assign busy_o = (left_q != 16'h0000);
   // Each level held HALF clocks so the synchroniser sees every edge
   always @(posedge clk_i) begin
      if (go_i) begin
         left_q <= n_i;
         tmr_q  <= 8'h00;
      end else if (busy_o) begin
         if (tmr_q == 8'(HALF - 1)) begin
            tmr_q <= 8'h00;
            pin_o <= ~pin_o;
            if (pin_o) begin
               left_q <= left_q - 16'h0001;
            end else begin
               edges_o <= edges_o + 16'h0001;
            end
         end else begin
            tmr_q <= tmr_q + 8'h01;
         end
      end
   end
endmodule // iec_evt_src
`default_nettype wire

// ### verif/iec_counter_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iec_cfg.svh"
module iec_counter_top_tb_top;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] nreq = 16'h0000, edges, base;
   logic [31:0] prdata;
   logic        pready, pslverr, pin, tog0, tog1, m0, m1, ovf, busy, t0, t1, tl;
   logic [32:0] note;
   logic [32:0] exp_q[$];
   int          failures = 0, checks_done = 0, cyc = 0, ta, tb, p, n1, nc, ntg;
   int          seen[$];

   iec_counter_top #(.PRESC_DIV(1)) dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .EVENT_INPUT_PIN_I(pin), .TOGGLE_OUTPUT_ZERO_O(tog0),
      .TOGGLE_OUTPUT_ONE_O(tog1), .MATCH_IRQ_ZERO_O(m0), .MATCH_IRQ_ONE_O(m1), .OVERFLOW_IRQ_O(ovf));
   iec_evt_src #(.HALF(6)) src (.clk_i(clk), .go_i(go), .n_i(nreq), .pin_o(pin), .edges_o(edges),
      .busy_o(busy));

   initial forever #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Driver notes the expected answer, the monitor below compares it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] er,
                      input logic ee);
      exp_q.push_back({ee, er});
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0; pen <= 1'b0;
      // Idle edge so a following call never reassigns psel in the same step
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask

   task automatic wait_pulse(input int sel, input int lim, output int t);
      int n;
      n = 0;
      t = -1;
      while (n < lim && t < 0) begin
         @(posedge clk);
         n++;
         if ((sel == 0 ? m0 : m1) === 1'b1) t = cyc;
      end
      if (t < 0) check("match pulse timeout", 32'h1, 32'h0);
   endtask

   task automatic pulses(input logic [15:0] n);
      base = edges;
      go <= 1'b1; nreq <= n;
      @(posedge clk);
      go <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected answer", 32'h1, 32'h0);
         end else begin
            note = exp_q.pop_front();
            check("prdata", prdata, note[31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
         end
      end
      if (!rst && ovf !== 1'b0) check("overflow irq", {31'h0, ovf}, 32'h0);
   end

   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial begin
      void'($urandom(2));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`IEC_OFS_CTRL, 32'h0);
      rd(`IEC_OFS_CMP0, 32'h0);
      rd(`IEC_OFS_COUNT, 32'h0);
      rd(`IEC_OFS_STATUS, 32'h0);
      apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h14, $urandom, 32'h0, 1'b1);
      p = $urandom;
      wr(`IEC_OFS_CMP1, p);
      rd(`IEC_OFS_CMP1, {16'h0000, p[15:0]});
      wr(`IEC_OFS_CTRL, 32'h5);
      rd(`IEC_OFS_COUNT, 32'h0);
      for (int k = 0; k < 3; k++) begin
         p = 2 + $urandom % 6;
         wr(`IEC_OFS_CMP0, p);
         wr(`IEC_OFS_CMP1, k == 0 ? p : (k == 1 ? p - 1 : p + 1));
         t0 = tog0;
         wr(`IEC_OFS_CTRL, 32'h1);
         repeat (3) @(posedge clk);
         check("start toggle", {31'h0, tog0}, {31'h0, ~t0});
         wait_pulse(0, 100, ta);
         wait_pulse(0, 100, tb);
         check("interval", tb - ta, p + 1);
         n1 = 0; nc = 0; ntg = 0; tl = tog1;
         repeat (2 * (p + 1)) begin
            @(posedge clk);
            if (m1 === 1'b1) n1++;
            if (m1 === 1'b1 && m0 === 1'b1) nc++;
            if (tog1 !== tl) ntg++;
            tl = tog1;
         end
         check("match one count", n1, k == 2 ? 0 : 2);
         check("toggle one count", ntg, k == 2 ? 0 : 2);
         if (k == 0) check("coincident matches", nc, 2);
         wr(`IEC_OFS_CTRL, 32'h0);
         rd(`IEC_OFS_COUNT, 32'h0);
      end
      wr(`IEC_OFS_CMP0, 32'd100);
      wr(`IEC_OFS_CMP1, 32'h0000FFFF);
      wr(`IEC_OFS_CTRL, 32'h1);
      wait_pulse(0, 300, ta);
      repeat (30) @(posedge clk);
      wr(`IEC_OFS_CMP0, 32'd10);
      wait_pulse(0, 70000, tb);
      check("wrapped interval", tb - ta, 32'h1000B);
      wr(`IEC_OFS_CTRL, 32'h0);
      wr(`IEC_OFS_CMP0, 32'h3);
      wr(`IEC_OFS_CMP1, 32'h2);
      t0 = tog0;
      t1 = tog1;
      // Event count mode, falling edges counted, run set, no other control bits set
      wr(`IEC_OFS_CTRL, 32'h23);
      rd(`IEC_OFS_CTRL, 32'h23);
      pulses(16'h000C);
      wait_pulse(1, 200, ta);
      check("edges at match one", {16'h0, edges - base}, 32'h2);
      seen.delete();
      for (int i = 0; i < 3; i++) begin
         wait_pulse(0, 200, ta);
         check("edges at match zero", {16'h0, edges - base}, 3 + 4 * i);
      end
      while (busy === 1'b1) @(posedge clk);
      check("toggle zero held", {31'h0, tog0}, {31'h0, t0});
      check("toggle one held", {31'h0, tog1}, {31'h0, t1});
      wr(`IEC_OFS_CTRL, 32'h0);
      wr(`IEC_OFS_CMP0, 32'h1);
      wr(`IEC_OFS_CMP1, 32'h1);
      wr(`IEC_OFS_CTRL, 32'h51);
      tl = tog1;
      n1 = 0;
      pulses(16'h0008);
      repeat (150) begin
         @(posedge clk);
         if (tog1 !== tl) seen.push_back(edges - base);
         if (m1 === 1'b1) n1++;
         tl = tog1;
      end
      check("masked match one", n1, 0);
      check("first toggle one edge", seen.size() > 0 ? seen[0] : 0, 3);
      check("second toggle one edge", seen.size() > 1 ? seen[1] : 0, 5);
      wr(`IEC_OFS_CTRL, 32'h0);
      give_verdict();
   end
endmodule // iec_counter_top_tb_top
`default_nettype wire
